// ===== src/atdtc_ctrl.sv
// Trigger source, power and sequence-irq control for an 8-channel converter.
// Assumes a classic Wishbone master and a converter core on the same clock.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "atdtc_params.svh"
module atdtc_ctrl #(
    parameter int NCH          = 8,
    parameter int NTRIG        = 4,
    parameter bit HAS_DED_TRIG = 1'b1
) (
    clk,
    sys_rst,
    wb_cyc_i,
    wb_stb_i,
    wb_we_i,
    wb_adr_i,
    wb_sel_i,
    wb_dat_i,
    wb_dat_o,
    wb_ack_o,
    analogDigIn,
    dedicatedTriggerInputs,
    waitMode,
    wakeIrq,
    seqCompleteFlag,
    convCompleteSet,
    coreCtrl,
    converterActive,
    resumeDiscard,
    irqOut
);
    input  wire logic                      clk;
    input  wire logic                      sys_rst;
    input  wire logic                      wb_cyc_i;
    input  wire logic                      wb_stb_i;
    input  wire logic                      wb_we_i;
    input  wire logic [7:0]                wb_adr_i;
    input  wire logic [3:0]                wb_sel_i;
    input  wire logic [31:0]               wb_dat_i;
    output logic      [31:0]               wb_dat_o;
    output logic                           wb_ack_o;
    input  wire logic [NCH-1:0]            analogDigIn;
    input  wire logic [NTRIG-1:0]          dedicatedTriggerInputs;
    input  wire logic                      waitMode;
    input  wire logic                      wakeIrq;
    input  wire logic                      seqCompleteFlag;
    input  wire logic [NCH-1:0]            convCompleteSet;
    output atdtc_pkg::atdtc_core_t         coreCtrl;
    output logic                           converterActive;
    output logic                           resumeDiscard;
    output logic                           irqOut;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    atdtc_pkg::atdtc_trig_t   trigQ;
    atdtc_pkg::atdtc_pwr_t    pwrQ;
    atdtc_pkg::atdtc_tstate_t tstateQ;
    logic [NCH-1:0]           convFlagQ;
    logic [NCH-1:0]           statArmQ;
    logic [`ATDTC_NEV-1:0]    irqStatQ;
    logic [`ATDTC_NEV-1:0]    irqMaskQ;
    logic                     abortQ;
    logic                     haltedQ;
    logic                     discardQ;

    logic                     access;
    logic                     wrAcc;
    logic                     rdAcc;
    logic                     ctrlWrite;
    logic                     resAccess;
    logic [2:0]               resIdx;
    logic                     dedTrigOn;
    logic [NTRIG-1:0]         trigSync;
    logic [NCH-1:0]           anaSync;
    logic                     srcLevel;
    logic                     trigHit;
    logic                     seqIrqFlag;
    logic [`ATDTC_NEV-1:0]    events;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Single-cycle ack; dropped the cycle after so each access acts once
    assign access    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrAcc     = access & wb_we_i & wb_sel_i[0];
    assign rdAcc     = access & ~wb_we_i;
    assign ctrlWrite = wrAcc & ((wb_adr_i == `ATDTC_OFS_TRIG) | (wb_adr_i == `ATDTC_OFS_PWR));
    assign resAccess = access & (wb_adr_i[7:5] == 3'(`ATDTC_OFS_RES0 >> 5)) & (wb_adr_i[1:0] == 2'b00);
    assign resIdx    = wb_adr_i[4:2];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Reserved bits are not stored and read as zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trigQ <= `ATDTC_RST_CTRL;
            pwrQ  <= `ATDTC_RST_CTRL;
        end else begin
            if (wrAcc && wb_adr_i == `ATDTC_OFS_TRIG) begin
                trigQ <= wb_dat_i[7:0] & `ATDTC_TRIG_MASK;
            end
            if (wrAcc && wb_adr_i == `ATDTC_OFS_PWR) begin
                pwrQ <= wb_dat_i[7:0] & `ATDTC_PWR_MASK;
            end
        end
    end

    // Abort pulse on any control write; no start issued
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            abortQ <= 1'b0;
        end else begin
            abortQ <= ctrlWrite;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NTRIG; gi++) begin : gTrig
            atdtc_sync uSyncT (
                .clk     (clk),
                .sys_rst (sys_rst),
                .pinIn   (dedicatedTriggerInputs[gi]),
                .syncOut (trigSync[gi])
            );
        end
        for (gi = 0; gi < NCH; gi++) begin : gAna
            atdtc_sync uSyncA (
                .clk     (clk),
                .sys_rst (sys_rst),
                .pinIn   (analogDigIn[gi]),
                .syncOut (anaSync[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Trigger source selection
    // ----------------------------------------------------------------
    // Stored select bit is ignored without the dedicated inputs
    assign dedTrigOn = HAS_DED_TRIG & trigQ.srcSel;

    // Reserved codes 1xx give a quiet source
    always_comb begin
        if (dedTrigOn) begin
            srcLevel = (trigQ.chanPick[2] == 1'b0) ? trigSync[trigQ.chanPick[1:0]] : 1'b0;
        end else begin
            srcLevel = anaSync[trigQ.chanPick];
        end
    end

    atdtc_edge uEdge (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sigIn        (srcLevel),
        .levelNotEdge (pwrQ.levelNotEdge),
        .polarity     (pwrQ.polarity),
        .hit          (trigHit)
    );

    // Trigger gating: enabled, powered, not halted, not aborting
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tstateQ <= atdtc_pkg::TRIG_IDLE;
        end else begin
            case (tstateQ)
                atdtc_pkg::TRIG_IDLE: begin
                    if (pwrQ.trigEnable && pwrQ.powerOn) begin
                        tstateQ <= atdtc_pkg::TRIG_ARMED;
                    end
                end
                atdtc_pkg::TRIG_ARMED: begin
                    if (!pwrQ.trigEnable || !pwrQ.powerOn || ctrlWrite) begin
                        tstateQ <= atdtc_pkg::TRIG_IDLE;
                    end else if (haltedQ) begin
                        tstateQ <= atdtc_pkg::TRIG_HELD;
                    end
                end
                atdtc_pkg::TRIG_HELD: begin
                    if (!haltedQ) begin
                        tstateQ <= atdtc_pkg::TRIG_ARMED;
                    end
                end
                default: tstateQ <= atdtc_pkg::TRIG_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power and wait mode
    // ----------------------------------------------------------------
    // Halt in wait only when wait power-down is set; resume on leaving wait, or on wake irq once power-down or power is cleared
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            haltedQ  <= 1'b0;
            discardQ <= 1'b0;
        end else begin
            // Resume mark wins over a same-cycle clear
            if (seqCompleteFlag || ctrlWrite) begin
                discardQ <= 1'b0;
            end
            if (waitMode && pwrQ.waitPd && pwrQ.powerOn) begin
                haltedQ <= 1'b1;
            end else if (haltedQ && (wakeIrq || !waitMode)) begin
                haltedQ  <= 1'b0;
                discardQ <= 1'b1;
            end
        end
    end

    // Core control outputs; recovery time is software's to wait out
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            coreCtrl <= '0;
        end else begin
            coreCtrl.run      <= pwrQ.powerOn & ~haltedQ;
            coreCtrl.abortSeq <= ctrlWrite;
            coreCtrl.trigger  <= (tstateQ == atdtc_pkg::TRIG_ARMED) & trigHit & ~ctrlWrite;
            coreCtrl.inBufEn  <= '0;
            if (pwrQ.trigEnable && !dedTrigOn) begin
                coreCtrl.inBufEn[trigQ.chanPick] <= 1'b1;
            end
        end
    end

    assign converterActive = coreCtrl.run;
    assign resumeDiscard   = discardQ;

    // ----------------------------------------------------------------
    // Conversion complete flags
    // ----------------------------------------------------------------
    // Normal clear needs a status read to arm each channel first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            convFlagQ <= '0;
            statArmQ  <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (convCompleteSet[i]) begin
                    convFlagQ[i] <= 1'b1; // set beats clear
                end else if (resAccess && resIdx == 3'(i)) begin
                    if (pwrQ.quickClr) begin
                        convFlagQ[i] <= 1'b0;
                    end else if (rdAcc && statArmQ[i]) begin
                        convFlagQ[i] <= 1'b0;
                    end
                end
                if (rdAcc && wb_adr_i == `ATDTC_OFS_STAT) begin
                    statArmQ[i] <= convFlagQ[i];
                end else if (resAccess && resIdx == 3'(i)) begin
                    statArmQ[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign seqIrqFlag = pwrQ.seqIrqEn & seqCompleteFlag;
    assign events     = {abortQ, coreCtrl.trigger, seqIrqFlag};

    // Sticky events; set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStatQ <= '0;
            irqMaskQ <= '0;
        end else begin
            if (wrAcc && wb_adr_i == `ATDTC_OFS_IRQMSK) begin
                irqMaskQ <= wb_dat_i[`ATDTC_NEV-1:0];
            end
            if (wrAcc && wb_adr_i == `ATDTC_OFS_IRQST) begin
                irqStatQ <= (irqStatQ & ~wb_dat_i[`ATDTC_NEV-1:0]) | events;
            end else begin
                irqStatQ <= irqStatQ | events;
            end
        end
    end

    // Live sequence request also gated by its own enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= seqIrqFlag | (|(irqStatQ & irqMaskQ));
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_dat_o <= '0;
        end else if (rdAcc) begin
            case (wb_adr_i)
                `ATDTC_OFS_TRIG:   wb_dat_o <= {24'h00_0000, trigQ};
                `ATDTC_OFS_PWR:    wb_dat_o <= {24'h00_0000, pwrQ[7:1], seqIrqFlag};
                `ATDTC_OFS_STAT:   wb_dat_o <= {{(32-NCH){1'b0}}, convFlagQ};
                `ATDTC_OFS_IRQST:  wb_dat_o <= {{(32-`ATDTC_NEV){1'b0}}, irqStatQ};
                `ATDTC_OFS_IRQMSK: wb_dat_o <= {{(32-`ATDTC_NEV){1'b0}}, irqMaskQ};
                default:           wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // atdtc_ctrl

// ===== src/atdtc_params.svh
// Constants for the converter trigger and control block: offsets, fields, resets.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef ATDTC_PARAMS_SVH
`define ATDTC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ATDTC_OFS_TRIG   8'h04
`define ATDTC_OFS_PWR    8'h08
`define ATDTC_OFS_STAT   8'h0C
`define ATDTC_OFS_RES0   8'h20
`define ATDTC_OFS_IRQST  8'h40
`define ATDTC_OFS_IRQMSK 8'h44

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATDTC_B_SRCSEL   7
`define ATDTC_B_PWRON    7
`define ATDTC_B_QCLR     6
`define ATDTC_B_WAITPD   5
`define ATDTC_B_LEVEL    4
`define ATDTC_B_POL      3
`define ATDTC_B_TEN      2
`define ATDTC_B_SIE      1
`define ATDTC_B_SIF      0
`define ATDTC_TRIG_MASK  8'h87
`define ATDTC_PWR_MASK   8'hFE

// ----------------------------------------------------------------
// Reset values and interrupt bits
// ----------------------------------------------------------------
`define ATDTC_RST_CTRL   8'h00
`define ATDTC_EV_SEQ     0
`define ATDTC_EV_TRIG    1
`define ATDTC_EV_ABORT   2
`define ATDTC_NEV        3

`endif

// ===== src/atdtc_pkg.sv
// Types for the converter trigger and control block.
// Assumes the constants header is included by users alongside.
package atdtc_pkg;

    // Trigger source control register view
    typedef struct packed {
        logic       srcSel;
        logic [3:0] rsvd;
        logic [2:0] chanPick;
    } atdtc_trig_t;

    // Power, trigger mode and irq control register view
    typedef struct packed {
        logic powerOn;
        logic quickClr;
        logic waitPd;
        logic levelNotEdge;
        logic polarity;
        logic trigEnable;
        logic seqIrqEn;
        logic seqIrqFlag;
    } atdtc_pwr_t;

    // Control outputs toward the converter core
    typedef struct packed {
        logic       run;
        logic       abortSeq;
        logic [7:0] inBufEn;
        logic       trigger;
    } atdtc_core_t;

    typedef enum logic [1:0] {
        TRIG_IDLE,
        TRIG_ARMED,
        TRIG_HELD
    } atdtc_tstate_t;

endpackage

// ===== src/atdtc_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes input is asynchronous to clk.
`timescale 1ns/1ps
module atdtc_sync (
    clk,
    sys_rst,
    pinIn,
    syncOut
);
    input  wire logic clk;
    input  wire logic sys_rst;
    input  wire logic pinIn;
    output logic      syncOut;

    logic stage1Q;

    // ----------------------------------------------------------------
    // Synchroniser chain
    // ----------------------------------------------------------------
    // First stage is read only by the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1Q <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1Q <= pinIn;
            syncOut <= stage1Q;
        end
    end
endmodule // atdtc_sync

// ===== src/atdtc_edge.sv
// Trigger sensitivity detector: edge or level of chosen polarity.
// Assumes a synchronised input on clk.
`timescale 1ns/1ps
module atdtc_edge (
    clk,
    sys_rst,
    sigIn,
    levelNotEdge,
    polarity,
    hit
);
    input  wire logic clk;
    input  wire logic sys_rst;
    input  wire logic sigIn;
    input  wire logic levelNotEdge;
    input  wire logic polarity;
    output logic      hit;

    logic prevQ;

    // Previous sample for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prevQ <= 1'b0;
        end else begin
            prevQ <= sigIn;
        end
    end

    // 00 fall, 01 rise, 10 low, 11 high
    always_comb begin
        case ({levelNotEdge, polarity})
            2'b00:   hit = prevQ & ~sigIn;
            2'b01:   hit = ~prevQ & sigIn;
            2'b10:   hit = ~sigIn;
            default: hit = sigIn;
        endcase
    end
endmodule // atdtc_edge

// ===== sim/atdtc_far_side.sv
// Far-side model: dedicated trigger pins and analog channel digital levels.
// Assumes the bench changes pin levels just after a rising clk edge.
`timescale 1ns/1ps
module atdtc_far_side (
    input  wire logic        clk,
    input  wire logic [7:0]  inBufEn,
    input  wire logic [11:0] pinLevel,
    output logic      [7:0]  analogDigIn,
    output logic      [3:0]  dedicatedTriggerInputs
);
    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    // A channel with its buffer off shows a changing pattern, never a level
    // A channel used as trigger carries logic levels, so its samples are useless
    assign analogDigIn = (pinLevel[7:0] & inBufEn) | ((clk ? 8'hA5 : 8'h5A) & ~inBufEn);
    // Dedicated pins follow the bench levels directly
    assign dedicatedTriggerInputs = pinLevel[11:8];
endmodule // atdtc_far_side

// ===== sim/atdtc_ctrl_monitor.sv
// Port-level assertions for the converter trigger and control block.
// Assumes a bind into atdtc_ctrl; one clock, synchronous reset.
`timescale 1ns/1ps
`include "atdtc_params.svh"
module atdtc_ctrl_monitor (
    input wire logic                   clk,
    input wire logic                   sys_rst,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_we_i,
    input wire logic [7:0]             wb_adr_i,
    input wire logic [3:0]             wb_sel_i,
    input wire logic [31:0]            wb_dat_i,
    input wire logic [31:0]            wb_dat_o,
    input wire logic                   wb_ack_o,
    input wire logic                   waitMode,
    input wire logic                   seqCompleteFlag,
    input wire atdtc_pkg::atdtc_core_t coreCtrl,
    input wire logic                   converterActive,
    input wire logic                   irqOut
);
    logic [7:0] trig_q;
    logic [7:0] pwr_q;

    // ------------------------------------------------------------
    // Control register shadows
    // ------------------------------------------------------------
    // Copied at the ack edge, one edge after the design; ack guards cover the lag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_q <= 8'h00;
            pwr_q <= 8'h00;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `ATDTC_OFS_TRIG) trig_q <= wb_dat_i[7:0];
            if (wb_adr_i == `ATDTC_OFS_PWR) pwr_q <= wb_dat_i[7:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Bus take, control write and a held wait request
    sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ctlWr; s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i inside {8'h04, 8'h08}); endsequence
    sequence s_wait; waitMode [*3]; endsequence

    property p_ack; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
    property p_abort; s_ctlWr |-> ##[1:2] coreCtrl.abortSeq; endproperty
    property p_abortCause; coreCtrl.abortSeq |-> wb_ack_o && wb_we_i && wb_adr_i inside {8'h04, 8'h08};
    endproperty
    property p_mirror; s_take ##0 (!wb_we_i && wb_adr_i == `ATDTC_OFS_PWR)
        |=> wb_dat_o[0] == (wb_dat_o[1] && $past(seqCompleteFlag)); endproperty
    property p_pwrOff; !pwr_q[7] && !wb_ack_o |-> !converterActive; endproperty
    property p_halt; s_wait ##0 (pwr_q[7] && pwr_q[5] && !wb_ack_o) |-> !converterActive; endproperty
    property p_run; s_wait ##0 (pwr_q[7] && !pwr_q[5] && !wb_ack_o && !$past(wb_ack_o))
        |-> converterActive; endproperty
    property p_inBuf; !trig_q[7] && pwr_q[2] && !wb_ack_o |-> coreCtrl.inBufEn == (8'h01 << trig_q[2:0]);
    endproperty
    property p_trigEn; coreCtrl.trigger |-> pwr_q[2]; endproperty
    property p_irq; pwr_q[1] && seqCompleteFlag && !wb_ack_o |=> irqOut; endproperty

    a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
    a_abort: assert property (p_abort) else $error("control write without abort");
    a_abortCause: assert property (p_abortCause) else $error("abort without write");
    a_mirror: assert property (p_mirror) else $error("irq flag mirror wrong");
    a_pwrOff: assert property (p_pwrOff) else $error("active while powered off");
    a_halt: assert property (p_halt) else $error("running in wait with power-down");
    a_run: assert property (p_run) else $error("halted in wait without power-down");
    a_inBuf: assert property (p_inBuf) else $error("input buffer not on source");
    a_trigEn: assert property (p_trigEn) else $error("trigger while disabled");
    a_irq: assert property (p_irq) else $error("irq missing with flag set");
endmodule // atdtc_ctrl_monitor

bind atdtc_ctrl atdtc_ctrl_monitor u_atdtc_ctrl_monitor (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .waitMode(waitMode), .seqCompleteFlag(seqCompleteFlag),
    .coreCtrl(coreCtrl), .converterActive(converterActive), .irqOut(irqOut)
);

// ===== sim/atdtc_ctrl_tb.sv
// Self-checking bench for the converter trigger and control block.
// Assumes classic Wishbone access and the far-side pin model.
`timescale 1ns/1ps
`include "atdtc_params.svh"
module atdtc_ctrl_tb;
    logic clk, sys_rst, cyc, stb, we, ack, waitMode, wakeIrq, seq_complete_flag, active, discard, irq;
    logic [7:0] adr, ccs, anaIn;
    logic [3:0] dedIn;
    logic [11:0] pins;
    logic [31:0] wdat, rdat, v;
    atdtc_pkg::atdtc_core_t core;
    int mismatches, totalChecks, k;
    int nAbort = 0, nTrig = 0;

    atdtc_ctrl u_atdtc_ctrl (
        .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .analogDigIn(anaIn),
        .dedicatedTriggerInputs(dedIn), .waitMode(waitMode), .wakeIrq(wakeIrq), .seqCompleteFlag(seq_complete_flag),
        .convCompleteSet(ccs), .coreCtrl(core), .converterActive(active), .resumeDiscard(discard),
        .irqOut(irq)
    );
    atdtc_far_side u_atdtc_far_side (
        .clk(clk), .inBufEn(core.inBufEn), .pinLevel(pins), .analogDigIn(anaIn),
        .dedicatedTriggerInputs(dedIn)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Strobe counters count high cycles; abort lasts one cycle, a level-mode trigger stays high while its level holds
    always @(posedge clk) begin
        if (core.abortSeq === 1'b1) nAbort <= nAbort + 1;
        if (core.trigger === 1'b1) nTrig <= nTrig + 1;
    end

    // ------------------------------------------------------------
    // Bus, pin and check tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Holds the request until ack is seen at an edge; bounded wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= a;
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        v = rdat;
        {cyc, stb, we} <= 3'h0;
        if (ack !== 1'b1) begin
            mismatches++;
            complete_run();
        end
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic pin(input logic [3:0] i, input logic l);
        @(posedge clk);
        pins[i] <= l;
        repeat (8) @(negedge clk);
    endtask
    task automatic hold(input logic w, input logic i);
        @(posedge clk);
        {waitMode, wakeIrq} <= {w, i};
        @(posedge clk);
        wakeIrq <= 1'b0;
        repeat (6) @(negedge clk);
    endtask
    task automatic flag(input logic [7:0] f);
        @(posedge clk);
        ccs <= f;
        @(posedge clk);
        ccs <= 8'h00;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        totalChecks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    initial begin
        sys_rst = 1'b1;
        {cyc, stb, we, waitMode, wakeIrq, seq_complete_flag} = 6'h00;
        {adr, ccs, pins, wdat} = 60'h0;
        {mismatches, totalChecks} = 64'h0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset state, stored fields and reserved bits
        rd(`ATDTC_OFS_TRIG);
        chk("trigRst", 8'h00, v[7:0]);
        rd(`ATDTC_OFS_PWR);
        chk("pwrRst", 8'h00, v[7:0]);
        wr(`ATDTC_OFS_TRIG, 8'hFF);
        rd(`ATDTC_OFS_TRIG);
        chk("trigRd", 8'h87, v[7:0]);
        // Each control write aborts once and starts nothing
        k = nAbort;
        wr(`ATDTC_OFS_TRIG, 8'h05);
        wr(`ATDTC_OFS_PWR, 8'h00);
        rd(8'h80);
        chk("unmapped", 8'h00, v[7:0]);
        chk("aborts", 8'(k + 2), 8'(nAbort));
        chk("noStart", 8'h00, 8'(active));
        // Power, wait halt and resume with a discard mark
        wr(`ATDTC_OFS_PWR, 8'h80);
        chk("runOn", 8'h01, 8'(active));
        hold(1'b1, 1'b0);
        chk("runWait", 8'h01, 8'(active));
        hold(1'b0, 1'b0);
        wr(`ATDTC_OFS_PWR, 8'hA0);
        hold(1'b1, 1'b0);
        chk("haltWait", 8'h00, 8'(active));
        hold(1'b0, 1'b1);
        chk("resume", 8'h01, 8'(active));
        chk("discard", 8'h01, 8'(discard));
        // All four sensitivities on dedicated input 1
        wr(`ATDTC_OFS_TRIG, 8'h81);
        for (int m = 0; m < 4; m++) begin
            pin(4'h9, !m[0]);
            wr(`ATDTC_OFS_PWR, {3'b100, m[1:0], 3'b100});
            k = nTrig;
            pin(4'h9, m[0]);
            chk("trigHit", 8'h01, 8'(nTrig > k));
            k = nTrig;
            pin(4'h9, !m[0]);
            if (!m[1]) chk("edgeOnly", 8'h00, 8'(nTrig - k));
        end
        // Reserved code, analog source with its buffer, then disable
        wr(`ATDTC_OFS_TRIG, 8'h85);
        k = nTrig;
        pin(4'h9, 1'b1);
        chk("rsvdQuiet", 8'h00, 8'(nTrig - k));
        wr(`ATDTC_OFS_TRIG, 8'h02);
        chk("bufOn", 8'h04, core.inBufEn);
        // Let the buffered level pass the synchroniser first
        repeat (3) @(negedge clk);
        k = nTrig;
        pin(4'h2, 1'b1);
        chk("anaHit", 8'h01, 8'(nTrig > k));
        wr(`ATDTC_OFS_PWR, 8'h98);
        k = nTrig;
        repeat (8) @(negedge clk);
        chk("trigOff", 8'h00, 8'(nTrig - k));
        // Sequence interrupt and its read-only mirror
        @(posedge clk);
        seq_complete_flag <= 1'b1;
        wr(`ATDTC_OFS_PWR, 8'h83);
        chk("irqOn", 8'h01, 8'(irq));
        rd(`ATDTC_OFS_PWR);
        chk("flagOn", 8'h83, v[7:0]);
        wr(`ATDTC_OFS_PWR, 8'h81);
        rd(`ATDTC_OFS_PWR);
        chk("flagOff", 8'h80, v[7:0]);
        chk("irqOff", 8'h00, 8'(irq));
        // Sticky abort event: raised, masked, cleared
        @(posedge clk);
        seq_complete_flag <= 1'b0;
        wr(`ATDTC_OFS_IRQMSK, 8'h04);
        chk("evIrq", 8'h01, 8'(irq));
        rd(`ATDTC_OFS_IRQST);
        chk("evSticky", 8'h04, v[7:0] & 8'h04);
        wr(`ATDTC_OFS_IRQMSK, 8'h00);
        chk("evMasked", 8'h00, 8'(irq));
        wr(`ATDTC_OFS_IRQST, 8'h07);
        rd(`ATDTC_OFS_IRQST);
        chk("evClear", 8'h00, v[7:0]);
        // Normal clear needs a status read before the result read
        flag(8'h08);
        rd(`ATDTC_OFS_RES0 + 8'h0C);
        rd(`ATDTC_OFS_STAT);
        chk("ccfKept", 8'h08, v[7:0]);
        rd(`ATDTC_OFS_RES0 + 8'h0C);
        rd(`ATDTC_OFS_STAT);
        chk("ccfCleared", 8'h00, v[7:0]);
        // Fast clear on any result access, that channel only
        wr(`ATDTC_OFS_PWR, 8'hC0);
        flag(8'h18);
        wr(`ATDTC_OFS_RES0 + 8'h0C, 8'h00);
        rd(`ATDTC_OFS_STAT);
        chk("ccfFast", 8'h10, v[7:0]);
        complete_run();
    end
endmodule // atdtc_ctrl_tb
